// ===== common/dp_regs_defs.svh
// Purpose: Offsets, bank and version codes and reset values of the debug port registers.
// Assumes: Offsets are byte addresses on a word-aligned debug port map.
// Notes:   Definitions only.
`ifndef PORT_REGS_DEFS_SVH
`define PORT_REGS_DEFS_SVH
`define OFS_PORT_ID 4'h0
`define OFS_BANKED 4'h4
`define OFS_RESEND_OR_SELECT 4'h8
`define OFS_READ_BUFFER 4'hc
`define BANK_CTRL_STAT 4'h0
`define BANK_LINK_CTRL 4'h1
`define BANK_TARGET_ID 4'h2
`define BANK_LINK_PROTO 4'h3
`define BANK_EVENT 4'h4
`define PROTOCOL_VERSION_MULTIDROP 4'h1
`define ARCH_VERSION_ONE 4'h1
`define ARCH_VERSION_TWO 4'h2
`define SELECT_BANK_RESET 4'h0
`define DATA_RESET 32'h0000_0000
`endif

// ===== common/dp_regs_pkg.sv
// Purpose: Types shared by the debug port identity and read-back logic.
// Assumes: Nothing beyond the constants header.
// Notes:   Holds types only.
package port_regs_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } collect_state_t;
  typedef enum logic [1:0] {
    RESP_OK = 2'b00,
    RESP_WAIT = 2'b01,
    RESP_FAULT = 2'b10
  } resp_t;
endpackage : port_regs_pkg

// ===== src/data_hold.sv
// Purpose: One 32-bit load-enabled holding register with a validity flag.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Used for both the captured access port result and the resent value.
`timescale 1ns/100ps
module data_hold (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control.
  input wire logic load,
  input wire logic invalidate,
  input wire logic [31:0] din,
  // Held value.
  output logic [31:0] dout,
  output logic valid
);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dout <= 32'h0000_0000;
      valid <= 1'b0;
    end else begin
      if (load) begin
        dout <= din;
      end
      // A fresh load wins over an invalidate in the same cycle.
      valid <= load | (valid & ~invalidate);
    end
  end
endmodule : data_hold

// ===== src/dp_id_readback.sv
// Purpose: Identity, event status, read buffer and resend registers of a debug port.
// Assumes: A link front end presents one decoded register access per req pulse.
// Notes:   Fields marked as arbitrary identity values are parameters.
`timescale 1ns/100ps
`include "dp_regs_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Protocol identity top nibble holds instance number.
// - Protocol version reads 0x1; bits 27:4 zero.
// - Protocol identity at offset 0x4, bank 0x3.
// - Addresses word aligned; low bits zero.
// - Port identity read-only at 0x0, any bank.
// - Revision, part number; bits 19:17 zero.
// - Bit 16 reports minimal port functions.
// - Architecture version reads 0x1 or 0x2.
// - Designer code fields; bit 0 reads one.
// - Event bit inverted; zero if absent.
// - Event status at offset 0x4, bank 0x4.
// - Serial read buffer returns previous capture.
// - Scan variant read buffer reads zero.
// - Read buffer invalid after one read.
// - Collecting access stalls until data ready.
// - Resend returns last delivered value.
// - Resend errors if impossible; scan reserved.
// - Select write-only in versions one, two.
// - Bank field picks register at 0x4.
module port_id_readback
  import port_regs_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h0,
  parameter logic [7:0] PART_NUMBER = 8'h00,
  parameter logic [3:0] ARCH_VERSION = `ARCH_VERSION_TWO,
  parameter bit MINIMAL_PORT = 1'b1,
  // Designer codes are arbitrary neutral values.
  parameter logic [3:0] DESIGNER_CONT = 4'h0,
  parameter logic [6:0] DESIGNER_CODE = 7'h01,
  parameter logic [3:0] INSTANCE_NUMBER = 4'h0,
  parameter bit SERIAL_VARIANT = 1'b1,
  parameter bit EVENT_PRESENT = 1'b1,
  parameter bit RESEND_SUPPORTED = 1'b1
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Debug port register access from the link front end.
  input wire logic reg_req,
  input wire logic reg_write,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic reg_ack,
  output resp_t reg_resp,
  output logic [31:0] reg_rdata,
  // Access port read requests and results.
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic acc_rvalid,
  input wire logic [31:0] acc_rdata,
  output logic acc_stall,
  // System event that needs attention, active high level.
  input wire logic event_pending,
  // Decoded bank for the outside control registers at offset 0x4.
  output logic [3:0] bank_select_field,
  output logic banked_other
);

  ////////////////////////////////////////////////////////////////////////////
  // Identity values.
  logic [31:0] debug_port_identity;
  logic [31:0] link_protocol_identity;
  logic [31:0] event_status;
  assign debug_port_identity = {REVISION, PART_NUMBER, 3'b000, MINIMAL_PORT,
                                ARCH_VERSION, DESIGNER_CONT, DESIGNER_CODE, 1'b1};
  assign link_protocol_identity = {INSTANCE_NUMBER, 24'h00_0000,
                                   `PROTOCOL_VERSION_MULTIDROP};
  // Event status is inverted so that zero means attention needed.
  assign event_status = {31'h0000_0000, EVENT_PRESENT & ~event_pending};

  ////////////////////////////////////////////////////////////////////////////
  // Address decode; the two low address bits are never part of the choice.
  logic [3:0] word_addr;
  logic hit_id;
  logic hit_banked;
  logic hit_eight;
  logic hit_rdbuf;
  logic rd;
  logic wr;
  assign word_addr = {reg_addr[3:2], 2'b00};
  assign hit_id = (word_addr == `OFS_PORT_ID);
  assign hit_banked = (word_addr == `OFS_BANKED);
  assign hit_eight = (word_addr == `OFS_RESEND_OR_SELECT);
  assign hit_rdbuf = (word_addr == `OFS_READ_BUFFER);
  assign rd = reg_req & ~reg_write;
  assign wr = reg_req & reg_write;

  ////////////////////////////////////////////////////////////////////////////
  // Bank select, written at offset 0x8; not readable back in versions one and two.
  logic [3:0] bank_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bank_r <= `SELECT_BANK_RESET;
    end else if (wr && hit_eight) begin
      bank_r <= reg_wdata[3:0];
    end
  end
  assign bank_select_field = bank_r;
  // Outside registers live at banks 0x0 to 0x2.
  assign banked_other = (bank_r == `BANK_CTRL_STAT) | (bank_r == `BANK_LINK_CTRL) |
                        (bank_r == `BANK_TARGET_ID);

  ////////////////////////////////////////////////////////////////////////////
  // Capture of access port reads and the resend value.
  collect_state_t st_r;
  collect_state_t st_nxt;
  logic cap_load;
  logic cap_inval;
  logic [31:0] cap_data;
  logic cap_valid;
  logic rs_load;
  logic [31:0] rs_data;
  logic rs_valid;
  logic collecting;
  logic rdbuf_deliver;
  logic acc_deliver;

  // A read is outstanding from its request until the result arrives.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (acc_req && !acc_write) begin
          st_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (acc_rvalid) begin
          st_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        if (acc_req && !acc_write) begin
          st_nxt = ST_WAIT;
        end else if (rdbuf_deliver || acc_req) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // A follow-up access waits while the original result is still in flight.
  assign collecting = (st_r == ST_WAIT);
  assign acc_stall = collecting & acc_req;
  assign acc_deliver = acc_req & ~collecting;
  assign rdbuf_deliver = rd & hit_rdbuf & ~collecting & SERIAL_VARIANT;
  assign cap_load = collecting & acc_rvalid;
  assign cap_inval = rdbuf_deliver;
  // The value handed out last is what resend repeats.
  assign rs_load = rdbuf_deliver | (acc_deliver & (st_r == ST_DONE));

  data_hold u_capture (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(cap_load),
    .invalidate(cap_inval),
    .din(acc_rdata),
    .dout(cap_data),
    .valid(cap_valid)
  );

  data_hold u_resend (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(rs_load),
    .invalidate(1'b0),
    .din(cap_data),
    .dout(rs_data),
    .valid(rs_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection.
  logic [31:0] banked_val;
  logic [31:0] rd_val;
  logic rd_fault;
  logic rd_wait;
  assign banked_val = (bank_r == `BANK_LINK_PROTO) ? link_protocol_identity :
                      (bank_r == `BANK_EVENT) ? event_status :
                      32'h0000_0000;
  // Resend cannot be served when nothing was delivered; scan variant reserves it.
  assign rd_fault = rd & hit_eight & (~SERIAL_VARIANT | ~RESEND_SUPPORTED | ~rs_valid);
  assign rd_wait = rd & hit_rdbuf & collecting & SERIAL_VARIANT;
  assign rd_val = hit_id ? debug_port_identity :
                  hit_banked ? banked_val :
                  (hit_eight && !rd_fault) ? rs_data :
                  (hit_rdbuf && SERIAL_VARIANT) ? cap_data :
                  32'h0000_0000;

  logic ack_r;
  resp_t resp_r;
  logic [31:0] rdata_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      resp_r <= RESP_OK;
      rdata_r <= `DATA_RESET;
    end else begin
      ack_r <= reg_req;
      resp_r <= rd_fault ? RESP_FAULT : (rd_wait ? RESP_WAIT : RESP_OK);
      if (rd && !rd_wait) begin
        rdata_r <= rd_val;
      end
    end
  end
  assign reg_ack = ack_r;
  assign reg_resp = resp_r;
  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_port_id;
    @(posedge clk_sys) disable iff (!rst_n)
    (rd && hit_id) |=> (reg_rdata[0] == 1'b1 && reg_rdata[19:17] == 3'b000 &&
                        reg_rdata[16] == MINIMAL_PORT && reg_rdata[15:12] == ARCH_VERSION);
  endproperty
  a_port_id: assert property (p_port_id) else $error("bad port identity");

  property p_proto_id;
    @(posedge clk_sys) disable iff (!rst_n)
    (rd && hit_banked && bank_r == 4'h3) |=>
      (reg_rdata == {INSTANCE_NUMBER, 28'h000_0001});
  endproperty
  a_proto_id: assert property (p_proto_id) else $error("bad protocol identity");

  property p_event;
    @(posedge clk_sys) disable iff (!rst_n)
    (rd && hit_banked && bank_r == 4'h4) |=>
      (reg_rdata == {31'h0, EVENT_PRESENT & ~$past(event_pending)});
  endproperty
  a_event: assert property (p_event) else $error("bad event status");

  // A read buffer read during an outstanding read must be told to retry, data untouched.
  property p_stall;
    @(posedge clk_sys) disable iff (!rst_n)
    (rd && hit_rdbuf && collecting && SERIAL_VARIANT) |=>
      (reg_resp == RESP_WAIT) && $stable(reg_rdata);
  endproperty
  a_stall: assert property (p_stall) else $error("follow-up not held off");

  property p_resend_fault;
    @(posedge clk_sys) disable iff (!rst_n)
    (rd && hit_eight && !rs_valid) |=> (reg_resp == RESP_FAULT);
  endproperty
  a_resend_fault: assert property (p_resend_fault) else $error("resend not refused");

  property p_reserved_bank;
    @(posedge clk_sys) disable iff (!rst_n)
    (rd && hit_banked && bank_r > `BANK_EVENT) |=> (reg_rdata == 32'h0000_0000);
  endproperty
  a_reserved_bank: assert property (p_reserved_bank) else $error("bad reserved bank");

  property p_banked_other;
    @(posedge clk_sys) disable iff (!rst_n)
    banked_other == (bank_select_field < `BANK_LINK_PROTO);
  endproperty
  a_banked_other: assert property (p_banked_other) else $error("bank decode wrong");

  property p_rdbuf_inval;
    @(posedge clk_sys) disable iff (!rst_n)
    rdbuf_deliver |=> !cap_valid || $past(cap_load);
  endproperty
  a_rdbuf_inval: assert property (p_rdbuf_inval) else $error("buffer still valid");

  property p_resend_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    (!rs_load) |=> (rs_data == $past(rs_data));
  endproperty
  a_resend_hold: assert property (p_resend_hold) else $error("resend value moved");

  property p_rdbuf_data;
    @(posedge clk_sys) disable iff (!rst_n)
    (rd && hit_rdbuf && !collecting) |=>
      (reg_rdata == (SERIAL_VARIANT ? $past(cap_data) : 32'h0));
  endproperty
  a_rdbuf_data: assert property (p_rdbuf_data) else $error("bad read buffer data");

  property p_select_wo;
    @(posedge clk_sys) disable iff (!rst_n)
    (wr && hit_eight) |=> (bank_select_field == $past(reg_wdata[3:0])) && !reg_resp[1];
  endproperty
  a_select_wo: assert property (p_select_wo) else $error("select write lost");

  c_fault: cover property (@(posedge clk_sys) disable iff (!rst_n) reg_resp == RESP_FAULT);
  c_stall: cover property (@(posedge clk_sys) disable iff (!rst_n) acc_stall);
  c_wait: cover property (@(posedge clk_sys) disable iff (!rst_n) rd_wait);
  c_resend: cover property (@(posedge clk_sys) disable iff (!rst_n)
                            rs_load ##[1:20] (rd && hit_eight));
endmodule : port_id_readback

// ===== tb/ap_model.sv
// Purpose: Access port model that answers reads after a fixed latency.
// Assumes: One read outstanding at a time; writes complete at once.
// Notes:   Data outside the valid pulse is inverted so stale values show.
`timescale 1ns/100ps
module acc_port_model #(
  parameter int LAT = 4
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Access port side of the block.
  input wire logic acc_req,
  input wire logic acc_write,
  output logic acc_rvalid,
  output logic [31:0] acc_rdata
);
  int cnt;
  logic [15:0] seq_r;
  logic [31:0] last_r;
  wire logic [31:0] data_nxt = {16'ha5c3, seq_r + 16'h1};
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    acc_rvalid <= 1'b0;
    acc_rdata <= ~last_r;
    if (!rst_n) begin
      cnt <= 0;
      seq_r <= 16'h0;
      last_r <= 32'h0;
    end else if (acc_req && !acc_write && cnt == 0) begin
      cnt <= LAT;
    end else if (cnt == 1) begin
      acc_rvalid <= 1'b1;
      acc_rdata <= data_nxt;
      last_r <= data_nxt;
      seq_r <= seq_r + 16'h1;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : acc_port_model

// ===== tb/debug_port_id_readback_regs_tb.sv
// Purpose: Self-checking bench for the debug port identity and read-back registers.
// Assumes: Serial variant with event and resend support.
// Notes:   Identity parameters below are arbitrary values.
`timescale 1ns/100ps
`include "dp_regs_defs.svh"
module debug_port_id_readback_regs_tb;
  import port_regs_pkg::*;
  localparam logic [31:0] ID_EXP = {4'h3, 8'h5a, 3'h0, 1'b1, `ARCH_VERSION_TWO, 4'h2, 7'h15,
                                    1'b1};
  localparam logic [31:0] LP_EXP = {4'h9, 24'h0, `PROTOCOL_VERSION_MULTIDROP};
  logic clk_sys, rst_n, reg_req, reg_write, reg_ack, acc_req, acc_write, acc_rvalid;
  logic acc_stall, event_pending, banked_other;
  logic [3:0] reg_addr, bank_select_field;
  logic [31:0] reg_wdata, reg_rdata, acc_rdata, got_d;
  resp_t reg_resp, got_r;
  int n_fail, n_checks, cyc, i;
  ////////////////////////////////////////////////////////////////////////////
  // Variant, event, resend, minimal and version settings keep their defaults.
  port_id_readback #(.REVISION(4'h3), .PART_NUMBER(8'h5a), .DESIGNER_CONT(4'h2),
    .DESIGNER_CODE(7'h15), .INSTANCE_NUMBER(4'h9)) port_id_readback_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .reg_req(reg_req), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_resp(reg_resp), .reg_rdata(reg_rdata),
    .acc_req(acc_req), .acc_write(acc_write), .acc_rvalid(acc_rvalid), .acc_rdata(acc_rdata),
    .acc_stall(acc_stall), .event_pending(event_pending),
    .bank_select_field(bank_select_field), .banked_other(banked_other));
  acc_port_model acc_port_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .acc_req(acc_req),
    .acc_write(acc_write), .acc_rvalid(acc_rvalid), .acc_rdata(acc_rdata));
  ////////////////////////////////////////////////////////////////////////////
  task end_sim();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task chk_data(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t data %h expected %h", $time, g, e);
    end
  endtask : chk_data
  task chk_resp(input resp_t g, input resp_t e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t resp %0d expected %0d", $time, g, e);
    end
  endtask : chk_resp
  // One access: request for one cycle, answer taken the cycle after.
  task reg_acc(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    #1;
    reg_req = 1'b1;
    reg_write = wr;
    reg_addr = a;
    reg_wdata = wd;
    @(posedge clk_sys);
    #1;
    reg_req = 1'b0;
    got_r = reg_resp;
    got_d = reg_rdata;
    chk_data({31'h0, reg_ack}, 32'h1);
  endtask : reg_acc
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc >= 2000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    {rst_n, reg_req, reg_write, acc_req, acc_write, event_pending} = 6'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    repeat (12) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    chk_data({26'h0, reg_ack, banked_other, bank_select_field}, 32'h10);
    reg_acc(1'b0, 4'h8, 32'h0);
    chk_resp(got_r, RESP_FAULT);
    $display("test resend_empty done");
    for (i = 0; i < 5; i += 4) begin
      reg_acc(1'b1, 4'h8, i);
      reg_acc(1'b0, 4'h0, 32'h0);
      chk_data(got_d, ID_EXP);
      chk_resp(got_r, RESP_OK);
    end
    $display("test port_identity done");
    reg_acc(1'b1, 4'h8, 32'h3);
    chk_data({31'h0, banked_other}, 32'h0);
    reg_acc(1'b0, 4'h4, 32'h0);
    chk_data(got_d, LP_EXP);
    reg_acc(1'b0, 4'h7, 32'h0);
    chk_data(got_d, LP_EXP);
    $display("test link_identity done");
    reg_acc(1'b1, 4'h8, 32'h4);
    reg_acc(1'b0, 4'h4, 32'h0);
    chk_data(got_d, 32'h1);
    event_pending = 1'b1;
    reg_acc(1'b0, 4'h4, 32'h0);
    chk_data(got_d, 32'h0);
    reg_acc(1'b1, 4'h8, 32'h5);
    reg_acc(1'b0, 4'h4, 32'h0);
    chk_data(got_d, 32'h0);
    reg_acc(1'b1, 4'h8, 32'h0);
    chk_data({27'h0, banked_other, bank_select_field}, 32'h10);
    $display("test banks_events done");
    @(posedge clk_sys);
    #1;
    acc_req = 1'b1;
    @(posedge clk_sys);
    #1;
    acc_req = 1'b0;
    reg_acc(1'b0, 4'hc, 32'h0);
    chk_resp(got_r, RESP_WAIT);
    // A follow-up access port write is held until the first read has landed.
    acc_req = 1'b1;
    acc_write = 1'b1;
    @(posedge clk_sys);
    #1;
    chk_data({31'h0, acc_stall}, 32'h1);
    for (i = 0; i < 20 && acc_stall === 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk_data({31'h0, acc_stall}, 32'h0);
    @(posedge clk_sys);
    #1;
    acc_req = 1'b0;
    acc_write = 1'b0;
    reg_acc(1'b0, 4'h8, 32'h0);
    chk_data(got_d, 32'ha5c3_0001);
    reg_acc(1'b0, 4'hc, 32'h0);
    chk_data(got_d, 32'ha5c3_0001);
    chk_resp(got_r, RESP_OK);
    for (i = 0; i < 2; i++) begin
      reg_acc(1'b0, 4'h8, 32'h0);
      chk_data(got_d, 32'ha5c3_0001);
    end
    $display("test read_buffer done");
    end_sim();
  end
endmodule : debug_port_id_readback_regs_tb
